// [hw/brd_pkg.sv]
// Package: constants, pin bundle and divisor table of the baud-rate divider
package brd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam int TABLE_DEPTH = 32;
  localparam int ENTRY_W = 19;
  localparam int DIV_W = 20;
  localparam int SLOW_W = 4;
  localparam int QUARTER_W = 2;

  // ----------------------------------------------------------------
  // Field positions inside the synchronised pin bundle
  // ----------------------------------------------------------------
  localparam int PIN_REF_POS = 7;
  localparam int PIN_GATE_POS = 6;
  localparam int PIN_LATCH_POS = 5;
  localparam int PIN_SEL_LSB = 0;
  localparam int PIN_W = 8;

  // ----------------------------------------------------------------
  // Reset values and divider limits
  // ----------------------------------------------------------------
  localparam logic [PIN_W-1:0] PIN_RESET = 8'h7f;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h1f;
  localparam logic [DIV_W-1:0] DIV_OFFSET = 20'h00002;
  localparam logic [DIV_W-1:0] DIV_MIN = 20'h00006;
  localparam logic [DIV_W-1:0] DIV_MAX = 20'h80001;

  // ----------------------------------------------------------------
  // Timing: new frequency must start within this time of a change
  // ----------------------------------------------------------------
  localparam real CLOCK_MHZ = 100.0;
  localparam real NEW_FREQ_US = 3.5;
  localparam int NEW_FREQ_CYCLES = int'($floor(NEW_FREQ_US * CLOCK_MHZ));

  // Synchronised pins travel together as one bundle
  typedef struct packed {
    logic ref_clk;
    logic gate_n;
    logic latch_gate;
    logic [SEL_W-1:0] sel;
  } brd_pins_type;

  // Table entries hold divisor minus two, so 19 bits span 2 to 2^19+1
  function automatic logic [ENTRY_W-1:0] brd_table(input logic [SEL_W-1:0] idx);
    case (idx)
      5'h00: brd_table = 19'h017fe;
      5'h01: brd_table = 19'h00ffe;
      5'h02: brd_table = 19'h00ae7;
      5'h03: brd_table = 19'h008ea;
      5'h04: brd_table = 19'h007fe;
      5'h05: brd_table = 19'h003fe;
      5'h06: brd_table = 19'h001fe;
      5'h07: brd_table = 19'h000fe;
      5'h08: brd_table = 19'h000a9;
      5'h09: brd_table = 19'h00098;
      5'h0a: brd_table = 19'h0007e;
      5'h0b: brd_table = 19'h00053;
      5'h0c: brd_table = 19'h0003e;
      5'h0d: brd_table = 19'h00029;
      5'h0e: brd_table = 19'h0001e;
      5'h0f: brd_table = 19'h0000e;
      5'h10: brd_table = 19'h0167e;
      5'h11: brd_table = 19'h00efe;
      5'h12: brd_table = 19'h00a38;
      5'h13: brd_table = 19'h0085b;
      5'h14: brd_table = 19'h0077e;
      5'h15: brd_table = 19'h003be;
      5'h16: brd_table = 19'h001de;
      5'h17: brd_table = 19'h000ee;
      5'h18: brd_table = 19'h0009e;
      5'h19: brd_table = 19'h0008e;
      5'h1a: brd_table = 19'h00076;
      5'h1b: brd_table = 19'h0004e;
      5'h1c: brd_table = 19'h0003a;
      5'h1d: brd_table = 19'h00026;
      5'h1e: brd_table = 19'h00004;
      5'h1f: brd_table = 19'h7ffff;
      default: brd_table = 19'h0000e;
    endcase
  endfunction

  // Length in reference ticks of the high (longer) or low half
  function automatic logic [DIV_W-1:0] brd_half(input logic [ENTRY_W-1:0] entry,
                                                input logic high_half);
    logic [DIV_W-1:0] total;
    total = {1'b0, entry} + DIV_OFFSET;
    brd_half = high_half ? ((total + 20'h00001) >> 1) : (total >> 1);
  endfunction

endpackage

// [hw/brd_divider.sv]
// Half-cycle divider core that turns reference ticks into the baud wave
module brd_divider #(
  parameter bit DEFER_UPDATE = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ref_tick,
  input wire logic [brd_pkg::ENTRY_W-1:0] entry_new,
  input wire logic entry_load,
  output logic baud_level,
  output logic baud_rise
);

  typedef enum logic [0:0] {
    BRD_PH_HIGH = 1'b0,
    BRD_PH_LOW = 1'b1
  } brd_phase_type;

  brd_phase_type phase_reg;
  logic [brd_pkg::DIV_W-1:0] count_reg;
  logic [brd_pkg::ENTRY_W-1:0] entry_reg;
  logic [brd_pkg::ENTRY_W-1:0] pend_reg;
  logic pend_valid_reg;
  logic half_end;
  logic [brd_pkg::ENTRY_W-1:0] entry_next;

  // ----------------------------------------------------------------
  // Divisor selection for the next half
  // ----------------------------------------------------------------
  assign half_end = ref_tick && (count_reg <= 20'h00001);
  assign entry_next = pend_valid_reg ? pend_reg : entry_reg;

  // Deferred mode parks the new divisor until the half ends
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_reg <= '0;
      pend_valid_reg <= 1'b0;
    end else if (ce) begin
      if (entry_load) begin
        pend_reg <= entry_new;
        pend_valid_reg <= DEFER_UPDATE;
      end else if (half_end) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase and half counter
  // ----------------------------------------------------------------
  // Immediate mode restarts on a fresh high half so the new rate starts at once
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase_reg <= BRD_PH_HIGH;
      entry_reg <= brd_pkg::brd_table(brd_pkg::SEL_RESET);
      count_reg <= brd_pkg::brd_half(brd_pkg::brd_table(brd_pkg::SEL_RESET), 1'b1);
      baud_rise <= 1'b0;
    end else if (ce) begin
      baud_rise <= 1'b0;
      if (entry_load && !DEFER_UPDATE) begin
        entry_reg <= entry_new;
        phase_reg <= BRD_PH_HIGH;
        count_reg <= brd_pkg::brd_half(entry_new, 1'b1);
        baud_rise <= 1'b1;
      end else if (half_end) begin
        entry_reg <= entry_next;
        case (phase_reg)
          BRD_PH_HIGH: begin
            phase_reg <= BRD_PH_LOW;
            count_reg <= brd_pkg::brd_half(entry_next, 1'b0);
          end
          BRD_PH_LOW: begin
            phase_reg <= BRD_PH_HIGH;
            count_reg <= brd_pkg::brd_half(entry_next, 1'b1);
            baud_rise <= 1'b1;
          end
          default: begin
            phase_reg <= BRD_PH_HIGH;
            count_reg <= brd_pkg::brd_half(entry_next, 1'b1);
          end
        endcase
      end else if (ref_tick) begin
        count_reg <= count_reg - 20'h00001;
      end
    end
  end

  assign baud_level = (phase_reg == BRD_PH_HIGH);

endmodule

// [hw/brd_top.sv]
// Top of the baud-rate divider: pin conditioning, select latch, outputs
// Functional notes
// - Divide reference by one of the 32 table divisors, from 6 to 2^19+1, for the baud output.
// - Even divisor gives square wave; odd one is high one tick longer.
// - Baud output is divided by sixteen onto a separate slow output.
// - Reference is echoed at full rate and at one quarter rate.
// - Low output gate disables both baud and slow baud outputs.
// - Undriven output gate reads high, so outputs default enabled.
// - Table of 32 entries, 19 bits each, indexed by the 5-bit select.
// - Select latch is transparent while its gate is high, holds when low.
// - A select change while transparent starts the new rate within 3.5 us; deferred builds wait for the end of the current half.
// - Build option defers a new divisor to the end of the current half.
// - Undriven select bits read as one; the latch gate has no default.
module brd_top #(
  parameter bit DEFER_UPDATE = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ref_clock_in,
  input wire logic output_gate_n,
  input wire logic output_gate_n_oe,
  input wire logic select_latch_gate,
  input wire logic [brd_pkg::SEL_W-1:0] select_in,
  input wire logic [brd_pkg::SEL_W-1:0] select_oe,
  output logic baud_out,
  output logic baud_slow_out,
  output logic ref_clock_out,
  output logic ref_quarter_out,
  output logic [brd_pkg::SEL_W-1:0] select_held
);

  brd_pkg::brd_pins_type pins_raw;
  brd_pkg::brd_pins_type sync1_reg;
  brd_pkg::brd_pins_type sync2_reg;
  brd_pkg::brd_pins_type sync3_reg;
  brd_pkg::brd_pins_type clean_reg;
  logic [brd_pkg::PIN_W-1:0] agree;
  logic ref_prev_reg;
  logic ref_tick;
  logic [brd_pkg::SEL_W-1:0] latch_reg;
  logic [brd_pkg::SEL_W-1:0] applied_reg;
  logic [brd_pkg::ENTRY_W-1:0] entry_reg;
  logic entry_load_reg;
  logic [brd_pkg::QUARTER_W-1:0] quarter_reg;
  logic [brd_pkg::SLOW_W-1:0] slow_reg;
  logic core_level;
  logic core_rise;

  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // A gate or select pin nobody drives falls back to its pull-up level
  always_comb begin
    pins_raw.ref_clk = ref_clock_in;
    pins_raw.gate_n = output_gate_n_oe ? output_gate_n : 1'b1;
    pins_raw.latch_gate = select_latch_gate;
    pins_raw.sel = (select_in & select_oe) | ~select_oe;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; stage one feeds stage two only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_reg <= brd_pkg::PIN_RESET;
      sync2_reg <= brd_pkg::PIN_RESET;
      sync3_reg <= brd_pkg::PIN_RESET;
    end else if (ce) begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign agree = ~(sync2_reg ^ sync3_reg);

  // A bit changes only when stages two and three agree, filtering glitches
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clean_reg <= brd_pkg::PIN_RESET;
    end else if (ce) begin
      clean_reg <= (sync3_reg & agree) | (clean_reg & ~agree);
    end
  end

  // ----------------------------------------------------------------
  // Reference tick
  // ----------------------------------------------------------------
  // One tick per reference rising edge; each reference level must last two clocks or more, so at most a quarter of the clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ref_prev_reg <= 1'b0;
    end else if (ce) begin
      ref_prev_reg <= clean_reg.ref_clk;
    end
  end

  assign ref_tick = clean_reg.ref_clk && !ref_prev_reg;

  // ----------------------------------------------------------------
  // Select latch and table lookup
  // ----------------------------------------------------------------
  // Level latch modelled as a clock-enabled register: follows while gate is high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      latch_reg <= brd_pkg::SEL_RESET;
    end else if (ce && clean_reg.latch_gate) begin
      latch_reg <= clean_reg.sel;
    end
  end

  // Any change of the held value loads a new entry; no strobe edge needed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      applied_reg <= brd_pkg::SEL_RESET;
      entry_reg <= brd_pkg::brd_table(brd_pkg::SEL_RESET);
      entry_load_reg <= 1'b0;
    end else if (ce) begin
      entry_load_reg <= 1'b0;
      if (latch_reg != applied_reg) begin
        applied_reg <= latch_reg;
        entry_reg <= brd_pkg::brd_table(latch_reg);
        entry_load_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Divider core
  // ----------------------------------------------------------------
  brd_divider #(
    .DEFER_UPDATE(DEFER_UPDATE)
  ) u_divider (
    .clock(clock),
    .sys_rst(sys_rst),
    .ce(ce),
    .ref_tick(ref_tick),
    .entry_new(entry_reg),
    .entry_load(entry_load_reg),
    .baud_level(core_level),
    .baud_rise(core_rise)
  );

  // ----------------------------------------------------------------
  // Secondary dividers
  // ----------------------------------------------------------------
  // Quarter-rate reference: two ticks high, two ticks low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      quarter_reg <= '0;
    end else if (ce && ref_tick) begin
      quarter_reg <= quarter_reg + 2'h1;
    end
  end

  // Counts baud rises even while gated so the phase survives a disable
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slow_reg <= '0;
    end else if (ce && core_rise) begin
      slow_reg <= slow_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // Gate masks only the pins; counters above never stop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      baud_out <= 1'b0;
      baud_slow_out <= 1'b0;
    end else if (ce) begin
      baud_out <= core_level & clean_reg.gate_n;
      baud_slow_out <= slow_reg[brd_pkg::SLOW_W-1] & clean_reg.gate_n;
    end
  end

  // Reference echoes are not gated
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ref_clock_out <= 1'b0;
      ref_quarter_out <= 1'b0;
      select_held <= brd_pkg::SEL_RESET;
    end else if (ce) begin
      ref_clock_out <= clean_reg.ref_clk;
      ref_quarter_out <= quarter_reg[brd_pkg::QUARTER_W-1];
      select_held <= applied_reg;
    end
  end

endmodule

// [testbench/brd_properties.sv]
// Checker: pin relations of the baud-rate divider
module brd_properties #(
  parameter bit DEFER_UPDATE = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic ref_clock_in,
  input wire logic output_gate_n,
  input wire logic output_gate_n_oe,
  input wire logic select_latch_gate,
  input wire logic [brd_pkg::SEL_W-1:0] select_in,
  input wire logic [brd_pkg::SEL_W-1:0] select_oe,
  input wire logic baud_out,
  input wire logic baud_slow_out,
  input wire logic ref_clock_out,
  input wire logic ref_quarter_out,
  input wire logic [brd_pkg::SEL_W-1:0] select_held
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // ----
  // Edge counters
  // ----
  logic ref_q, baud_q, slow_q, quar_q, q_ok, s_arm, s_ok;
  logic [3:0] q_cnt, s_cnt;
  logic [brd_pkg::SEL_W-1:0] held_q;
  wire logic gate_on = output_gate_n | ~output_gate_n_oe;
  wire logic sel_chg = select_held != held_q;
  wire logic keep = gate_on & ~sel_chg;
  wire logic q_chg = ref_quarter_out ^ quar_q;
  wire logic s_chg = baud_slow_out ^ slow_q;
  wire logic [3:0] q_sum = q_cnt + {3'h0, ref_clock_out & ~ref_q};
  wire logic [3:0] s_sum = s_cnt + {3'h0, baud_out & ~baud_q};

  // Gating or a restart hides rises, so two clean slow edges are needed
  always_ff @(posedge clock) begin
    ref_q <= ref_clock_out;
    baud_q <= baud_out;
    slow_q <= baud_slow_out;
    quar_q <= ref_quarter_out;
    held_q <= select_held;
    if (sys_rst) begin
      q_cnt <= 4'h0;
      s_cnt <= 4'h0;
      q_ok <= 1'b0;
      s_arm <= 1'b0;
      s_ok <= 1'b0;
    end else begin
      q_cnt <= q_chg ? 4'h0 : q_sum;
      s_cnt <= s_chg ? 4'h0 : s_sum;
      q_ok <= q_ok | q_chg;
      s_arm <= (s_arm | s_chg) & keep;
      s_ok <= (s_ok | (s_arm & s_chg)) & keep;
    end
  end

  // ----
  // Assertions
  // ----
  sequence gate_low_run;
    (output_gate_n_oe && !output_gate_n) [*8];
  endsequence
  sequence sel_steady;
    (select_latch_gate && $stable(select_in) && $stable(select_oe)) [*8];
  endsequence
  a_gate_forces_low:
    assert property (gate_low_run |-> !baud_out && !baud_slow_out)
    else $error("baud output active while gated");
  a_sel_applied:
    assert property (sel_steady |-> select_held == (select_in | ~select_oe))
    else $error("select not applied");
  a_latch_holds:
    assert property ((!select_latch_gate) [*8] ##1 !select_latch_gate |-> $stable(select_held))
    else $error("held select moved while latch closed");
  a_new_rate_fast:
    assert property (!DEFER_UPDATE && sel_chg && gate_on && select_held != 5'h1f
      |-> ##[0:350] $changed(baud_out))
    else $error("new rate started late");
  a_ref_echo:
    assert property ($rose(ref_clock_in) |-> ##[3:7] $rose(ref_clock_out))
    else $error("reference echo missing");
  a_quarter_rate:
    assert property (q_ok && q_chg |-> q_sum == 4'h2)
    else $error("quarter output off rate");
  a_slow_div16:
    assert property (s_ok && s_chg |-> s_sum == 4'h8)
    else $error("slow output off rate");
  // Re-enabling shows a half already under way, so only rises well after enable count
  a_baud_min_half:
    assert property (disable iff (sys_rst || !gate_on) $rose(baud_out) && $past(gate_on, 8)
      |-> baud_out [*8])
    else $error("baud high half too short");
endmodule

bind brd_top brd_properties #(.DEFER_UPDATE(DEFER_UPDATE)) i_brd_properties (
  .clock, .sys_rst, .ce, .ref_clock_in, .output_gate_n, .output_gate_n_oe, .select_latch_gate,
  .select_in, .select_oe, .baud_out, .baud_slow_out, .ref_clock_out, .ref_quarter_out,
  .select_held
);

// [testbench/brd_link_model.sv]
// Partner: serial logic that times every baud period it receives
module brd_link_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic baud_out,
  output logic meas_valid,
  output logic [31:0] meas
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;

  // Report high and low lengths in clocks at each rise of the baud wave
  always_ff @(posedge clock) begin
    last_q <= baud_out;
    meas_valid <= 1'b0;
    if (sys_rst) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
    end else if (baud_out && !last_q) begin
      meas_valid <= 1'b1;
      meas <= {hi_cnt, lo_cnt};
      hi_cnt <= 16'h0001;
      lo_cnt <= 16'h0000;
    end else if (baud_out) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end else begin
      lo_cnt <= lo_cnt + 16'h0001;
    end
  end
endmodule

// [testbench/baud_rate_divider_32sel_tb.sv]
// Testbench: divisor choice, latch, pull-ups and gating of the baud divider
module baud_rate_divider_32sel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ref_clock_in = 1'b0;
  logic output_gate_n = 1'b1;
  logic output_gate_n_oe = 1'b1;
  logic select_latch_gate = 1'b1;
  logic [brd_pkg::SEL_W-1:0] select_in = 5'h1e;
  logic [brd_pkg::SEL_W-1:0] select_oe = 5'h1f;
  logic baud_out, baud_slow_out, ref_clock_out, ref_quarter_out, meas_valid;
  logic [brd_pkg::SEL_W-1:0] select_held;
  logic [31:0] meas;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int checked = 0;
  int ref_div = 0;
  // Entries exercised and their divisors; reference period is 8 clocks
  logic [4:0] sel_tab [3] = '{5'h1e, 5'h0f, 5'h0d};
  int div_tab [3] = '{6, 16, 43};

  always #5 clock = ~clock;

  // Reference at 12.5 MHz keeps each level four clocks long
  always @(negedge clock) begin
    ref_div = (ref_div + 1) % 8;
    ref_clock_in <= (ref_div < 4);
  end

  brd_top i_brd_top (.clock, .sys_rst, .ce(1'b1), .ref_clock_in, .output_gate_n,
    .output_gate_n_oe, .select_latch_gate, .select_in, .select_oe, .baud_out, .baud_slow_out,
    .ref_clock_out, .ref_quarter_out, .select_held);
  brd_link_model i_brd_link_model (.clock, .sys_rst, .baud_out, .meas_valid, .meas);

  // ----
  // Tasks
  // ----
  task automatic final_report();
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One falling edge under a bound of 4000 counted separately by each wait
  task automatic guard(inout int n);
    @(negedge clock);
    n++;
    if (n > 4000) begin
      err_total++;
      final_report();
    end
  endtask

  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (baud_out !== lvl) guard(n);
  endtask

  // Select an entry, skip the settling periods, then expect two full periods
  task automatic rate(input logic [4:0] sel, input int div);
    int n;
    n = 0;
    @(negedge clock);
    select_in = sel;
    repeat (3) begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
    end
    repeat (3) @(negedge clock);
    repeat (2) exp_q.push_back({16'(((div + 1) / 2) * 8), 16'((div / 2) * 8)});
    while (exp_q.size() > 0) guard(n);
  endtask

  // Compare each measured period with the oldest note
  always @(posedge clock) begin
    if (meas_valid === 1'b1 && exp_q.size() > 0) begin
      check(meas, exp_q.pop_front());
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    int k;
    void'($urandom(81));
    repeat (2) @(posedge clock);
    @(negedge clock);
    check({25'h0, baud_out, baud_slow_out, select_held}, {25'h0, 2'b00, 5'h1f});
    sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) rate(sel_tab[i], div_tab[i]);
    for (int i = 0; i < 3; i++) begin
      k = $urandom_range(2);
      rate(sel_tab[k], div_tab[k]);
    end
    // Long run at the fastest rate lets the slow output toggle a few times
    rate(5'h1e, 6);
    repeat (2000) @(negedge clock);
    // Closed latch ignores a new select until it opens again
    select_latch_gate = 1'b0;
    repeat (10) @(negedge clock);
    k = 1 + $urandom_range(1);
    select_in = sel_tab[k];
    repeat (30) @(negedge clock);
    check({27'h0, select_held}, 32'h1e);
    select_latch_gate = 1'b1;
    repeat (20) @(negedge clock);
    check({27'h0, select_held}, {27'h0, sel_tab[k]});
    rate(sel_tab[k], div_tab[k]);
    // Undriven select bits read high
    select_in = 5'h1e;
    select_oe = 5'h01;
    rate(5'h00, 6);
    check({27'h0, select_held}, 32'h1e);
    select_oe = 5'h00;
    repeat (20) @(negedge clock);
    check({27'h0, select_held}, 32'h1f);
    select_in = 5'h1e;
    @(negedge clock);
    select_oe = 5'h1f;
    rate(5'h1e, 6);
    // Gate low holds both outputs low; an undriven gate pin enables
    output_gate_n = 1'b0;
    repeat (10) @(negedge clock);
    for (int i = 0; i < 100; i++) begin
      @(negedge clock);
      check({30'h0, baud_out, baud_slow_out}, 32'h0);
    end
    output_gate_n_oe = 1'b0;
    rate(5'h1e, 6);
    output_gate_n = 1'b1;
    output_gate_n_oe = 1'b1;
    // Second reset in mid-run
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    check({25'h0, baud_out, baud_slow_out, select_held}, {25'h0, 2'b00, 5'h1f});
    sys_rst = 1'b0;
    rate(5'h0d, 43);
    final_report();
  end
endmodule
